/* File: rtl/bpi_pkg.sv */
// shared constants for the block-transfer parameter and interrupt registers
package bpi_pkg;

    // host register port geometry
    localparam int ADDR_W  = 17;
    localparam int DATA_W  = 16;

    // register offsets, byte addresses as printed
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 17'h0_8004;
    localparam logic [ADDR_W-1:0] OFF_DST_LO   = 17'h0_8010;
    localparam logic [ADDR_W-1:0] OFF_DST_HI   = 17'h0_8012;
    localparam logic [ADDR_W-1:0] OFF_PITCH    = 17'h0_8014;
    localparam logic [ADDR_W-1:0] OFF_WIDTH    = 17'h0_8018;
    localparam logic [ADDR_W-1:0] OFF_HEIGHT   = 17'h0_801C;
    localparam logic [ADDR_W-1:0] OFF_BG       = 17'h0_8020;
    localparam logic [ADDR_W-1:0] OFF_FG       = 17'h0_8024;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 17'h0_8030;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN   = 17'h0_8032;
    localparam logic [ADDR_W-1:0] OFF_IND_PORT = 17'h0_002A;
    localparam logic [ADDR_W-1:0] OFF_WINDOW   = 17'h1_0000;

    // field widths and positions
    localparam int DST_W        = 21;
    localparam int DST_HI_W     = 5;
    localparam int PITCH_W      = 11;
    localparam int SIZE_W       = 10;
    localparam int COL_W        = 16;
    localparam int COL8_W       = 8;
    localparam int FLAG_BIT     = 0;
    localparam int EN_BIT       = 0;
    localparam int BUSY_BIT     = 0;
    localparam int FULL_BIT     = 4;
    localparam int NOTEMPTY_BIT = 6;

    // configuration pin decode: this pin high selects the indirect host interface
    localparam int CFG_W          = 3;
    localparam int CFG_INDIRECT_BIT = 2;

    // reset values
    localparam logic [15:0] RST_REG16 = 16'h0000;

endpackage

/* File: rtl/bpi_skid2.sv */
// two-entry buffer with valid and ready on both sides, outputs from flops
module bpi_skid2 #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic         flush_i,
    // filling side
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    // draining side
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);

    logic         out_valid_q;
    logic [W-1:0] out_data_q;
    logic         skid_valid_q;
    logic [W-1:0] skid_data_q;
    wire          push = in_valid_i & ~skid_valid_q;
    wire          move = ~out_valid_q | out_ready_i;

    assign in_ready_o  = ~skid_valid_q;
    assign out_valid_o = out_valid_q;
    assign out_data_o  = out_data_q;

    // the second entry only fills while the drain side stalls
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_valid_q  <= 1'b0;
            out_data_q   <= '0;
            skid_valid_q <= 1'b0;
            skid_data_q  <= '0;
        end else if (flush_i) begin
            out_valid_q  <= 1'b0;
            skid_valid_q <= 1'b0;
        end else if (move && skid_valid_q) begin
            out_valid_q  <= 1'b1;
            out_data_q   <= skid_data_q;
            skid_valid_q <= 1'b0;
        end else if (move) begin
            out_valid_q  <= push;
            out_data_q   <= in_data_i;
        end else if (push) begin
            skid_valid_q <= 1'b1;
            skid_data_q  <= in_data_i;
        end
    end

endmodule

/* File: rtl/bpi_blit_param_irq_regs.sv */
// parameter and completion-interrupt registers of the block-transfer engine
// What this block does
// - hold 21-bit destination start address
// - hold 11-bit line pitch in words
// - pitch used only for rectangular transfers
// - width in pixels is field plus one
// - height in lines is field plus one
// - background colour: expansion background, transparency key
// - foreground colour: expansion foreground, solid fill
// - 16 bpp all bits, 8 bpp low byte
// - completion sets status flag bit zero
// - write one clears flag, zero keeps
// - enable bit zero gates completion interrupt
// - direct interface moves data through window
// - busy reads one while transfer runs
module bpi_blit_param_irq_regs (
    // clock and reset
    input  wire logic                           ref_clk_i,
    input  wire logic                           rst_i,
    input  wire logic                           soft_rst_i,
    // host register port
    input  wire logic [bpi_pkg::ADDR_W-1:0]     host_addr_i,
    input  wire logic                           host_wr_i,
    input  wire logic                           host_rd_i,
    input  wire logic [bpi_pkg::DATA_W-1:0]     host_wdata_i,
    output logic      [bpi_pkg::DATA_W-1:0]     host_rdata_o,
    output logic                                host_rvalid_o,
    // configuration pins
    input  wire logic [bpi_pkg::CFG_W-1:0]      host_interface_config_pins_i,
    // engine status and control
    input  wire logic                           eng_busy_i,
    input  wire logic                           eng_done_i,
    input  wire logic                           eng_fifo_full_i,
    input  wire logic                           eng_fmt_16bpp_i,
    input  wire logic                           eng_dst_linear_i,
    // engine parameters
    output logic      [bpi_pkg::DST_W-1:0]      eng_dst_addr_o,
    output logic      [bpi_pkg::PITCH_W-1:0]    eng_pitch_o,
    output logic      [bpi_pkg::SIZE_W:0]       eng_width_px_o,
    output logic      [bpi_pkg::SIZE_W:0]       eng_height_lines_o,
    output logic      [bpi_pkg::COL_W-1:0]      eng_bg_colour_o,
    output logic      [bpi_pkg::COL_W-1:0]      eng_fg_colour_o,
    // pixel data to the engine
    output logic      [bpi_pkg::DATA_W-1:0]     eng_wr_data_o,
    output logic                                eng_wr_valid_o,
    input  wire logic                           eng_wr_ready_i,
    // pixel data from the engine
    input  wire logic [bpi_pkg::DATA_W-1:0]     eng_rd_data_i,
    input  wire logic                           eng_rd_valid_i,
    output logic                                eng_rd_pop_o,
    // interrupt request
    output logic                                irq_o
);
    import bpi_pkg::*;

    // configuration pin synchroniser
    logic [CFG_W-1:0] cfg_meta_q;
    logic [CFG_W-1:0] cfg_sync_q;

    // registers
    logic [DST_W-1:0]   dst_q;
    logic [PITCH_W-1:0] pitch_q;
    logic [SIZE_W-1:0]  width_q;
    logic [SIZE_W-1:0]  height_q;
    logic [COL_W-1:0]   bg_q;
    logic [COL_W-1:0]   fg_q;
    logic               flag_q;
    logic               flag_d;
    logic               irq_en_q;

    // registered outputs
    logic [DST_W-1:0]   dst_out_q;
    logic [PITCH_W-1:0] pitch_out_q;
    logic [SIZE_W:0]    width_out_q;
    logic [SIZE_W:0]    height_out_q;
    logic [COL_W-1:0]   bg_out_q;
    logic [COL_W-1:0]   fg_out_q;
    logic [DATA_W-1:0]  rdata_q;
    logic               rvalid_q;
    logic               pop_q;
    logic               irq_q;

    // buffer handshake
    logic               buf_in_ready;

    // the pins come from outside the clock domain: two flops before use
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_meta_q <= '0;
            cfg_sync_q <= '0;
        end else begin
            cfg_meta_q <= host_interface_config_pins_i;
            cfg_sync_q <= cfg_meta_q;
        end
    end

    // address decode
    wire direct_if   = ~cfg_sync_q[CFG_INDIRECT_BIT];
    wire sel_status  = (host_addr_i == OFF_STATUS);
    wire sel_dst_lo  = (host_addr_i == OFF_DST_LO);
    wire sel_dst_hi  = (host_addr_i == OFF_DST_HI);
    wire sel_pitch   = (host_addr_i == OFF_PITCH);
    wire sel_width   = (host_addr_i == OFF_WIDTH);
    wire sel_height  = (host_addr_i == OFF_HEIGHT);
    wire sel_bg      = (host_addr_i == OFF_BG);
    wire sel_fg      = (host_addr_i == OFF_FG);
    wire sel_stat    = (host_addr_i == OFF_IRQ_STAT);
    wire sel_en      = (host_addr_i == OFF_IRQ_EN);
    // window only answers in direct mode, the port only in indirect mode
    wire sel_data    = (direct_if & (host_addr_i == OFF_WINDOW))
                     | (~direct_if & (host_addr_i == OFF_IND_PORT));

    // write strobes
    wire wr_dst_lo   = host_wr_i & sel_dst_lo;
    wire wr_dst_hi   = host_wr_i & sel_dst_hi;
    wire wr_pitch    = host_wr_i & sel_pitch;
    wire wr_width    = host_wr_i & sel_width;
    wire wr_height   = host_wr_i & sel_height;
    wire wr_bg       = host_wr_i & sel_bg;
    wire wr_fg       = host_wr_i & sel_fg;
    wire wr_stat     = host_wr_i & sel_stat;
    wire wr_en       = host_wr_i & sel_en;
    wire wr_data     = host_wr_i & sel_data;
    wire rd_data     = host_rd_i & sel_data;

    // completion flag: a done pulse in the clearing cycle still sets it
    wire flag_clr    = wr_stat & host_wdata_i[FLAG_BIT];
    assign flag_d    = eng_done_i | (flag_q & ~flag_clr);

    // parameter registers, all cleared by either reset
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dst_q    <= '0;
            pitch_q  <= '0;
            width_q  <= '0;
            height_q <= '0;
            bg_q     <= RST_REG16;
            fg_q     <= RST_REG16;
        end else if (soft_rst_i) begin
            dst_q    <= '0;
            pitch_q  <= '0;
            width_q  <= '0;
            height_q <= '0;
            bg_q     <= RST_REG16;
            fg_q     <= RST_REG16;
        end else begin
            if (wr_dst_lo) dst_q[15:0]    <= host_wdata_i;
            if (wr_dst_hi) dst_q[DST_W-1:16] <= host_wdata_i[DST_HI_W-1:0];
            if (wr_pitch)  pitch_q  <= host_wdata_i[PITCH_W-1:0];
            if (wr_width)  width_q  <= host_wdata_i[SIZE_W-1:0];
            if (wr_height) height_q <= host_wdata_i[SIZE_W-1:0];
            if (wr_bg)     bg_q     <= host_wdata_i;
            if (wr_fg)     fg_q     <= host_wdata_i;
        end
    end

    // interrupt flag and enable
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            flag_q   <= 1'b0;
            irq_en_q <= 1'b0;
        end else if (soft_rst_i) begin
            flag_q   <= 1'b0;
            irq_en_q <= 1'b0;
        end else begin
            flag_q   <= flag_d;
            if (wr_en) irq_en_q <= host_wdata_i[EN_BIT];
        end
    end

    // values handed to the engine
    wire [SIZE_W:0]    width_px   = {1'b0, width_q} + 11'd1;
    wire [SIZE_W:0]    height_ln  = {1'b0, height_q} + 11'd1;
    // pitch is zeroed for linear transfers and goes to no display path
    wire [PITCH_W-1:0] pitch_eff  = eng_dst_linear_i ? '0 : pitch_q;
    // 8 bpp colours keep only their low byte
    wire [COL_W-1:0]   bg_eff     = eng_fmt_16bpp_i ? bg_q
                                  : {{(COL_W-COL8_W){1'b0}}, bg_q[COL8_W-1:0]};
    wire [COL_W-1:0]   fg_eff     = eng_fmt_16bpp_i ? fg_q
                                  : {{(COL_W-COL8_W){1'b0}}, fg_q[COL8_W-1:0]};

    // outputs come straight from flops, one cycle behind the registers
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dst_out_q    <= '0;
            pitch_out_q  <= '0;
            width_out_q  <= '0;
            height_out_q <= '0;
            bg_out_q     <= '0;
            fg_out_q     <= '0;
            irq_q        <= 1'b0;
        end else begin
            dst_out_q    <= dst_q;
            pitch_out_q  <= pitch_eff;
            width_out_q  <= width_px;
            height_out_q <= height_ln;
            bg_out_q     <= bg_eff;
            fg_out_q     <= fg_eff;
            irq_q        <= flag_q & irq_en_q;
        end
    end

    // status: full also reflects the local buffer so the host polls one bit
    wire buf_full    = eng_fifo_full_i | ~buf_in_ready;
    wire [DATA_W-1:0] status_word = (DATA_W'(eng_busy_i) << BUSY_BIT)
                                  | (DATA_W'(buf_full) << FULL_BIT)
                                  | (DATA_W'(eng_wr_valid_o) << NOTEMPTY_BIT);
    wire [DATA_W-1:0] rdata_win   = eng_rd_valid_i ? eng_rd_data_i : '0;

    // read selection; unmapped addresses read zero
    wire [DATA_W-1:0] rd_mux =
          ({DATA_W{sel_status}} & status_word)
        | ({DATA_W{sel_dst_lo}} & dst_q[15:0])
        | ({DATA_W{sel_dst_hi}} & DATA_W'(dst_q[DST_W-1:16]))
        | ({DATA_W{sel_pitch}}  & DATA_W'(pitch_q))
        | ({DATA_W{sel_width}}  & DATA_W'(width_q))
        | ({DATA_W{sel_height}} & DATA_W'(height_q))
        | ({DATA_W{sel_bg}}     & bg_q)
        | ({DATA_W{sel_fg}}     & fg_q)
        | ({DATA_W{sel_stat}}   & DATA_W'(flag_q))
        | ({DATA_W{sel_en}}     & DATA_W'(irq_en_q))
        | ({DATA_W{sel_data}}   & rdata_win);

    // a pop takes a cycle to reach the engine, so a read right behind it is not popped
    wire pop_d = rd_data & eng_rd_valid_i & ~pop_q;

    // read answer one cycle after the strobe
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
            pop_q    <= 1'b0;
        end else begin
            rdata_q  <= host_rd_i ? rd_mux : rdata_q;
            rvalid_q <= host_rd_i;
            pop_q    <= pop_d;
        end
    end

    // write data path: a stalled engine loses no word until both buffer entries are full; a further write is dropped
    bpi_skid2 #(
        .W (DATA_W)
    ) u_wbuf (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .flush_i     (soft_rst_i),
        .in_valid_i  (wr_data),
        .in_data_i   (host_wdata_i),
        .in_ready_o  (buf_in_ready),
        .out_valid_o (eng_wr_valid_o),
        .out_data_o  (eng_wr_data_o),
        .out_ready_i (eng_wr_ready_i)
    );

    // output wiring
    assign host_rdata_o       = rdata_q;
    assign host_rvalid_o      = rvalid_q;
    assign eng_dst_addr_o     = dst_out_q;
    assign eng_pitch_o        = pitch_out_q;
    assign eng_width_px_o     = width_out_q;
    assign eng_height_lines_o = height_out_q;
    assign eng_bg_colour_o    = bg_out_q;
    assign eng_fg_colour_o    = fg_out_q;
    assign eng_rd_pop_o       = pop_q;
    assign irq_o              = irq_q;

    // checks on the design's own registers and outputs
    AST_DONE_SETS_FLAG: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        eng_done_i && !soft_rst_i |=> flag_q ##1 (irq_o == irq_en_q || $changed(irq_en_q)))
        else $error("completion did not set the flag");

    AST_W1C_CLEARS: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_stat && host_wdata_i[FLAG_BIT] && !eng_done_i |=> !flag_q)
        else $error("write of one did not clear the flag");

    AST_W0_KEEPS: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_stat && !host_wdata_i[FLAG_BIT] && flag_q && !soft_rst_i |=> flag_q)
        else $error("write of zero disturbed the flag");

    AST_IRQ_MASKED: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !irq_en_q |=> !irq_o)
        else $error("interrupt raised while disabled");

    AST_IRQ_AND: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        flag_q && irq_en_q |=> irq_o)
        else $error("interrupt missing with flag and enable set");

    AST_WIDTH_PLUS1: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_width && !soft_rst_i |=> ##1
            (eng_width_px_o == ({1'b0, $past(host_wdata_i[SIZE_W-1:0], 2)} + 11'd1)))
        else $error("width output is not field plus one");

    AST_HEIGHT_PLUS1: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_height && !soft_rst_i |=> ##1
            (eng_height_lines_o == ({1'b0, $past(host_wdata_i[SIZE_W-1:0], 2)} + 11'd1)))
        else $error("height output is not field plus one");

    AST_PITCH_LINEAR: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        eng_dst_linear_i |=> (eng_pitch_o == '0))
        else $error("pitch passed on for a linear transfer");

    AST_COLOUR_8BPP: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !eng_fmt_16bpp_i |=> (eng_fg_colour_o[15:8] == 8'h00)
            && (eng_bg_colour_o[7:0] == $past(bg_q[7:0])))
        else $error("8 bpp colour not limited to low byte");

    AST_BUSY_READ: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        host_rd_i && sel_status |=> host_rvalid_o
            && (host_rdata_o[BUSY_BIT] == $past(eng_busy_i)))
        else $error("busy status read back wrong");

    AST_WINDOW_PUSH: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_data && buf_in_ready && !soft_rst_i |=> eng_wr_valid_o)
        else $error("data window write did not reach the engine");

    AST_SOFT_RESET: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        soft_rst_i |=> (width_q == '0) && !flag_q && !irq_en_q && (dst_q == '0))
        else $error("software reset left a register set");

    AST_DST_OUT: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_dst_lo && !soft_rst_i |=> ##1
            (eng_dst_addr_o[15:0] == $past(host_wdata_i, 2)))
        else $error("destination address low half not passed on");

    AST_COLOUR_16BPP: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        eng_fmt_16bpp_i |=> (eng_fg_colour_o == $past(fg_q))
            && (eng_bg_colour_o == $past(bg_q)))
        else $error("16 bpp colour not passed on in full");

    AST_DATA_POP: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        rd_data && eng_rd_valid_i && !eng_rd_pop_o |=> eng_rd_pop_o)
        else $error("data read did not pop the engine word");

endmodule

/* File: verification/bpi_engine_model.sv */
// behavioural engine on the far side of the pixel stream
module bpi_engine_model (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // stall request from the bench
    input  wire logic        stall_i,
    // words arriving from the block
    input  wire logic [15:0] wr_data_i,
    input  wire logic        wr_valid_i,
    output logic             wr_ready_o,
    // words offered to the host
    output logic [15:0]      rd_data_o,
    output logic             rd_valid_o,
    input  wire logic        rd_pop_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] got [$];
    // ready drops while stalled, so the buffer must hold what arrives
    assign wr_ready_o = ~stall_i;
    assign rd_valid_o = ~rst_i;
    // keep accepted words in arrival order for the bench
    always @(posedge ref_clk_i) begin
        if (!rst_i && wr_valid_i === 1'b1 && wr_ready_o) begin
            got.push_back(wr_data_i);
        end
    end
    // offered word steps on each pop and is held otherwise
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= 16'h5a00;
        end else if (rd_pop_i) begin
            rd_data_o <= rd_data_o + 16'h0001;
        end
    end
endmodule

/* File: verification/bpi_blit_param_irq_regs_test.sv */
// self-checking bench for the block-transfer parameter and interrupt registers
module bpi_blit_param_irq_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import bpi_pkg::*;
    typedef struct packed {logic [15:0] val; logic [15:0] msk;} bpi_exp_s;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              srst = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic [15:0]       wdata = '0;
    logic [2:0]        cfg = 3'b000;
    logic              busy = 1'b0;
    logic              done = 1'b0;
    logic              full = 1'b0;
    logic              fmt = 1'b1;
    logic              lin = 1'b0;
    logic              stall = 1'b0;
    logic [15:0]       rdata, ewd, erd, bg, fg;
    logic              rvalid, ewv, ewr, erv, pop, irq;
    logic [20:0]       dst;
    logic [10:0]       pitch, wpx, hpx;
    logic [15:0]       v [7];
    logic [15:0]       w [5];
    int                n_mismatch = 0;
    int                checks = 0;
    int                seed = 71;
    bpi_exp_s          expq [$];
    bpi_exp_s          ecur;
    localparam logic [ADDR_W-1:0] OFS [7] = '{OFF_DST_LO, OFF_DST_HI, OFF_PITCH, OFF_WIDTH,
                                              OFF_HEIGHT, OFF_BG, OFF_FG};
    localparam logic [15:0] MSK [7] = '{16'hffff, 16'h001f, 16'h07ff, 16'h03ff, 16'h03ff,
                                        16'hffff, 16'hffff};

    bpi_blit_param_irq_regs bpi_blit_param_irq_regs_i (
        .ref_clk_i(clk), .rst_i(rst), .soft_rst_i(srst), .host_addr_i(addr),
        .host_wr_i(wr), .host_rd_i(rd), .host_wdata_i(wdata), .host_rdata_o(rdata),
        .host_rvalid_o(rvalid), .host_interface_config_pins_i(cfg), .eng_busy_i(busy),
        .eng_done_i(done), .eng_fifo_full_i(full), .eng_fmt_16bpp_i(fmt),
        .eng_dst_linear_i(lin), .eng_dst_addr_o(dst), .eng_pitch_o(pitch),
        .eng_width_px_o(wpx), .eng_height_lines_o(hpx), .eng_bg_colour_o(bg),
        .eng_fg_colour_o(fg), .eng_wr_data_o(ewd), .eng_wr_valid_o(ewv),
        .eng_wr_ready_i(ewr), .eng_rd_data_i(erd), .eng_rd_valid_i(erv),
        .eng_rd_pop_o(pop), .irq_o(irq));

    bpi_engine_model bpi_engine_model_i (
        .ref_clk_i(clk), .rst_i(rst), .stall_i(stall), .wr_data_i(ewd), .wr_valid_i(ewv),
        .wr_ready_o(ewr), .rd_data_o(erd), .rd_valid_o(erv), .rd_pop_i(pop));

    // 10 MHz clock
    always #50 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude;
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one-cycle strobes, so back-to-back calls leave an idle cycle
    task automatic wreg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic rreg(input logic [ADDR_W-1:0] a, input logic [15:0] e, input logic [15:0] m);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        expq.push_back('{e, m});
        @(negedge clk);
        rd = 1'b0;
    endtask

    task automatic pulse_done;
        @(negedge clk);
        done = 1'b1;
        @(negedge clk);
        done = 0;
    endtask

    // bounded wait for the engine to collect n words
    task automatic wait_got(input int n);
        int k;
        k = 0;
        while (bpi_engine_model_i.got.size() < n && k < 20) begin
            @(negedge clk);
            k++;
        end
        chk("engine word count", bpi_engine_model_i.got.size(), n);
    endtask

    // read answers are matched against the oldest outstanding note
    always @(negedge clk) begin
        if (rvalid === 1'b1) begin
            ecur = (expq.size() > 0) ? expq.pop_front() : bpi_exp_s'{16'hdead, 16'hffff};
            chk("read data", rdata & ecur.msk, ecur.val & ecur.msk);
        end
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        conclude();
    end

    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        tick(2);
        foreach (OFS[i]) rreg(OFS[i], 16'h0000, 16'hffff);
        rreg(OFF_STATUS, 16'h0000, 16'hffff);
        rreg(OFF_IRQ_STAT, 16'h0000, 16'hffff);
        rreg(OFF_IRQ_EN, 16'h0000, 16'hffff);
        rreg(17'h0_8040, 16'h0000, 16'hffff);
        chk("width after reset", wpx, 11'h001);
        chk("height after reset", hpx, 11'h001);
        // 16 bpp rectangular, then 8 bpp linear
        for (int p = 0; p < 2; p++) begin
            fmt = (p == 0);
            lin = (p == 1);
            foreach (OFS[i]) begin
                v[i] = $random(seed) & MSK[i];
                wreg(OFS[i], v[i]);
            end
            foreach (OFS[i]) rreg(OFS[i], v[i], MSK[i]);
            tick(2);
            chk("dst", dst, {v[1][4:0], v[0]});
            chk("pitch", pitch, lin ? 0 : v[2][10:0]);
            chk("width", wpx, v[3][9:0] + 1);
            chk("height", hpx, v[4][9:0] + 1);
            chk("bg", bg, fmt ? v[5] : {8'h00, v[5][7:0]});
            chk("fg", fg, fmt ? v[6] : {8'h00, v[6][7:0]});
        end
        // completion flag, mask and clear
        wreg(OFF_IRQ_EN, 16'h0000);
        pulse_done();
        tick(3);
        chk("irq masked", irq, 1'b0);
        rreg(OFF_IRQ_STAT, 16'h0001, 16'h0001);
        wreg(OFF_IRQ_STAT, 16'h0000);
        rreg(OFF_IRQ_STAT, 16'h0001, 16'h0001);
        wreg(OFF_IRQ_EN, 16'h0001);
        tick(2);
        chk("irq enabled", irq, 1'b1);
        wreg(OFF_IRQ_EN, 16'h0000);
        tick(2);
        chk("irq enable cleared", irq, 1'b0);
        wreg(OFF_IRQ_EN, 16'h0001);
        wreg(OFF_IRQ_STAT, 16'h0001);
        tick(2);
        chk("irq flag cleared", irq, 1'b0);
        rreg(OFF_IRQ_STAT, 16'h0000, 16'h0001);
        // busy and full status
        busy = 1'b1;
        rreg(OFF_STATUS, 16'h0001, 16'h0051);
        busy = 1'b0;
        full = 1'b1;
        rreg(OFF_STATUS, 16'h0010, 16'h0051);
        full = 1'b0;
        // direct window writes into a stalled engine
        foreach (w[i]) w[i] = $random(seed);
        stall = 1'b1;
        wreg(OFF_WINDOW, w[0]);
        rreg(OFF_STATUS, 16'h0040, 16'h0050);
        wreg(OFF_WINDOW, w[1]);
        rreg(OFF_STATUS, 16'h0050, 16'h0050);
        wreg(OFF_WINDOW, w[2]);
        stall = 1'b0;
        wait_got(2);
        chk("word 0", bpi_engine_model_i.got[0], w[0]);
        chk("word 1", bpi_engine_model_i.got[1], w[1]);
        rreg(OFF_STATUS, 16'h0000, 16'h0050);
        rreg(OFF_WINDOW, 16'h5a00, 16'hffff);
        tick(2);
        rreg(OFF_WINDOW, 16'h5a01, 16'hffff);
        tick(2);
        // indirect mode: only the data port moves words
        cfg = 3'b100;
        tick(4);
        wreg(OFF_WINDOW, w[3]);
        wreg(OFF_IND_PORT, w[4]);
        wait_got(3);
        chk("port word", bpi_engine_model_i.got[2], w[4]);
        rreg(OFF_WINDOW, 16'h0000, 16'hffff);
        tick(2);
        rreg(OFF_IND_PORT, 16'h5a02, 16'hffff);
        // software reset clears the registers
        @(negedge clk);
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        tick(2);
        chk("width after soft reset", wpx, 11'h001);
        rreg(OFF_WIDTH, 16'h0000, 16'hffff);
        rreg(OFF_IRQ_EN, 16'h0000, 16'hffff);
        // hardware reset in mid-run must clear a written register again
        wreg(OFF_FG, 16'h1234);
        @(negedge clk);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(2);
        chk("fg after reset", fg, 16'h0000);
        rreg(OFF_FG, 16'h0000, 16'hffff);
        tick(4);
        chk("unanswered reads", expq.size(), 0);
        conclude();
    end
endmodule
